// [rtl/ccc_pkg.sv]
package ccc_pkg;
   // register offsets
   localparam logic [7:0] ADDR_SELF_TEST_TALLY     = 8'h57;
   localparam logic [7:0] ADDR_BACK_CHANNEL_SETUP  = 8'h58;
   localparam logic [7:0] ADDR_PATH_CTL_FIRST      = 8'h59;
   localparam logic [7:0] ADDR_PATH_CTL_SECOND     = 8'h5a;
   localparam logic [7:0] ADDR_REMOTE_TX_ADDR      = 8'h5b;
   // back channel setup fields
   localparam int         BCS_FWD_ALL_BIT          = 7;
   localparam int         BCS_FWD_MATCH_BIT        = 6;
   localparam int         BCS_SELF_ACK_BIT         = 5;
   localparam int         BCS_FORCE_ON_BIT         = 4;
   localparam int         BCS_CHECK_GEN_BIT        = 3;
   localparam int         BCS_RATE_MSB             = 2;
   // first path control fields
   localparam int         PC1_KEEP_LOCAL_BIT       = 7;
   localparam int         PC1_GPIO_MSB             = 1;
   // remote address fields
   localparam int         RTA_LOCK_BIT             = 0;
   // reset values
   localparam logic [7:0] RST_SELF_TEST_TALLY      = 8'h00;
   localparam logic [7:0] RST_BACK_CHANNEL_UPPER   = 8'h18;
   localparam logic [7:0] RST_PATH_CTL_FIRST       = 8'h00;
   localparam logic [7:0] RST_PATH_CTL_SECOND      = 8'h00;
   localparam logic [7:0] RST_REMOTE_TX_ADDR       = 8'h00;
   localparam logic [2:0] RST_RATE_SEL             = 3'h0;
   // rate codes
   localparam logic [2:0] RATE_2M5                 = 3'h0;
   localparam logic [2:0] RATE_10M                 = 3'h4;
   localparam logic [2:0] RATE_25M                 = 3'h5;
   localparam logic [2:0] RATE_50M                 = 3'h6;
   localparam logic [2:0] RATE_100M                = 3'h7;
   // one-hot rate selects
   localparam logic [4:0] RATE_OH_2M5              = 5'h01;
   localparam logic [4:0] RATE_OH_10M              = 5'h02;
   localparam logic [4:0] RATE_OH_25M              = 5'h04;
   localparam logic [4:0] RATE_OH_50M              = 5'h08;
   localparam logic [4:0] RATE_OH_100M             = 5'h10;
endpackage

// [rtl/ccc_regs.sv]
`timescale 1ns/100ps
// Functional notes
// [RL1] read-only 8-bit self-test error count, resets to zero
// [RL2] bit 7 set forwards every local transaction to the remote side
// [RL3] bit 6 set forwards a local transaction only on address match
// [RL4] bit 5 set acknowledges every write locally, ignoring lock and remote ack
// [RL5] bit 4 (reset 1) forces back channel on; else needs a forward bit
// [RL6] force-on bit writable only from the local bus, remote writes ignored
// [RL7] bit 3 (reset 1) enables back-channel check generation
// [RL8] rate codes 000/100/101/110/111 give 2.5/10/25/50/100 Mbps; others reserved
// [RL9] rate field default taken from strap when power-down pin rises
// [RL10] controller should enable self-ack before remote rate change
// [RL11] keep-local bit blocks forward-channel loading of path registers
// [RL12] gpio count 00 none, 01 one, 10 two, 11 four
// [RL13] gpio count loaded remotely; local value persists only under keep-local
// [RL14] second path register loaded remotely unless keep-local set
// [RL15] remote 7-bit address captured into bits 7:1 from forward channel
// [RL16] lock bit 0 stops auto capture; written address holds
// [RL17] reserved bits and codes have no effect; writable ones just hold
module ccc_regs (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // local register port
   input  wire logic       loc_wr,
   input  wire logic       loc_rd,
   input  wire logic [7:0] loc_addr,
   input  wire logic [7:0] loc_wdata,
   output logic      [7:0] loc_rdata,
   output logic            loc_rvalid,
   // register writes arriving over the control channel
   input  wire logic       rem_wr,
   input  wire logic [7:0] rem_addr,
   input  wire logic [7:0] rem_wdata,
   // forward-channel loading
   input  wire logic       fwd_path_load,
   input  wire logic [7:0] fwd_path_first,
   input  wire logic [7:0] fwd_path_second,
   input  wire logic       fwd_addr_load,
   input  wire logic [6:0] fwd_remote_addr,
   // self test
   input  wire logic       self_test_err,
   input  wire logic       self_test_clr,
   // pins
   input  wire logic       power_down_active_low_pin,
   input  wire logic [2:0] rate_strap_pin,
   // transaction decode from the local target
   input  wire logic       txn_valid,
   input  wire logic       txn_addr_match,
   input  wire logic       txn_is_write,
   // control outputs
   output logic            txn_forward,
   output logic            txn_self_ack,
   output logic            reverse_link_en,
   output logic            reverse_link_check_gen_en,
   output logic [4:0]      reverse_link_rate_onehot,
   output logic [3:0]      forward_gpio_en,
   output logic [7:0]      path_setup_second,
   output logic [6:0]      remote_transmitter_addr
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   logic [3:0] pin_s;
   logic       pwr_up_s;
   logic [2:0] strap_s;
   logic       pwr_up_prev_q;
   logic       pwr_up_rise;

   ccc_sync2 #(
      .W(4)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in ({power_down_active_low_pin, rate_strap_pin}),
      .sync_out (pin_s)
   );

   assign pwr_up_s = pin_s[3];
   assign strap_s  = pin_s[2:0];

   // power-down release edge detect
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwr_up_prev_q <= 1'b0;
      end else begin
         pwr_up_prev_q <= pwr_up_s;
      end
   end

   // a pin held high through reset still gives one rise after release
   assign pwr_up_rise = pwr_up_s & ~pwr_up_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // write decode
   logic loc_bcs_wr;
   logic rem_bcs_wr;
   logic loc_pc1_wr;
   logic loc_pc2_wr;
   logic loc_rta_wr;
   logic rem_pc1_wr;
   logic rem_pc2_wr;
   logic rem_rta_wr;

   assign loc_bcs_wr = loc_wr & (loc_addr == ccc_pkg::ADDR_BACK_CHANNEL_SETUP);
   assign loc_pc1_wr = loc_wr & (loc_addr == ccc_pkg::ADDR_PATH_CTL_FIRST);
   assign loc_pc2_wr = loc_wr & (loc_addr == ccc_pkg::ADDR_PATH_CTL_SECOND);
   assign loc_rta_wr = loc_wr & (loc_addr == ccc_pkg::ADDR_REMOTE_TX_ADDR);
   // local access wins a same-cycle collision
   assign rem_bcs_wr = ~loc_wr & rem_wr & (rem_addr == ccc_pkg::ADDR_BACK_CHANNEL_SETUP);
   assign rem_pc1_wr = ~loc_wr & rem_wr & (rem_addr == ccc_pkg::ADDR_PATH_CTL_FIRST);
   assign rem_pc2_wr = ~loc_wr & rem_wr & (rem_addr == ccc_pkg::ADDR_PATH_CTL_SECOND);
   assign rem_rta_wr = ~loc_wr & rem_wr & (rem_addr == ccc_pkg::ADDR_REMOTE_TX_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // self-test error tally, saturating
   logic [7:0] tally_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tally_q <= ccc_pkg::RST_SELF_TEST_TALLY; // [RL1]
      end else if (self_test_clr) begin
         // an error in the clearing cycle is counted, not lost
         tally_q <= self_test_err ? 8'h01 : ccc_pkg::RST_SELF_TEST_TALLY;
      end else if (self_test_err && tally_q != 8'hff) begin
         tally_q <= tally_q + 8'h01; // [RL1]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // back channel setup, upper bits
   logic [7:3] bcs_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bcs_q <= ccc_pkg::RST_BACK_CHANNEL_UPPER[7:3]; // [RL5] [RL7]
      end else if (loc_bcs_wr) begin
         bcs_q <= loc_wdata[7:3];
      end else if (rem_bcs_wr) begin
         // force-on keeps its value on remote writes
         bcs_q[7:5] <= rem_wdata[7:5];
         bcs_q[3]   <= rem_wdata[3];
         bcs_q[4]   <= bcs_q[4]; // [RL6]
      end
   end

   // rate field: strap load on power-down release
   logic [2:0] rate_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rate_q <= ccc_pkg::RST_RATE_SEL;
      end else if (pwr_up_rise) begin
         rate_q <= strap_s; // [RL9]
      end else if (loc_bcs_wr) begin
         rate_q <= loc_wdata[ccc_pkg::BCS_RATE_MSB:0];
      end else if (rem_bcs_wr) begin
         rate_q <= rem_wdata[ccc_pkg::BCS_RATE_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // path control registers with keep-local override
   logic [7:0] pc1_q;
   logic [7:0] pc2_q;
   logic       keep_local_path_settings;

   assign keep_local_path_settings = pc1_q[ccc_pkg::PC1_KEEP_LOCAL_BIT];

   // first path register: keep-local and reserved bits are local,
   // gpio count comes from the forward channel unless kept
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc1_q <= ccc_pkg::RST_PATH_CTL_FIRST;
      end else if (loc_pc1_wr) begin
         pc1_q <= loc_wdata; // [RL17]
      end else if (rem_pc1_wr) begin
         pc1_q <= rem_wdata;
      end else if (fwd_path_load && !keep_local_path_settings) begin
         // only the gpio count follows the forward channel [RL11]
         pc1_q[ccc_pkg::PC1_GPIO_MSB:0] <= fwd_path_first[ccc_pkg::PC1_GPIO_MSB:0]; // [RL13]
      end
   end

   // second path register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc2_q <= ccc_pkg::RST_PATH_CTL_SECOND;
      end else if (loc_pc2_wr) begin
         pc2_q <= loc_wdata;
      end else if (rem_pc2_wr) begin
         pc2_q <= rem_wdata;
      end else if (fwd_path_load && !keep_local_path_settings) begin
         pc2_q <= fwd_path_second; // [RL11] [RL14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // remote transmitter address with lock
   logic [7:0] rta_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rta_q <= ccc_pkg::RST_REMOTE_TX_ADDR;
      end else if (loc_rta_wr) begin
         rta_q <= loc_wdata;
      end else if (rem_rta_wr) begin
         rta_q <= rem_wdata;
      end else if (fwd_addr_load && !rta_q[ccc_pkg::RTA_LOCK_BIT]) begin // [RL16]
         rta_q[7:1] <= fwd_remote_addr; // [RL15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port, one cycle latency
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         loc_rdata  <= 8'h00;
         loc_rvalid <= 1'b0;
      end else begin
         loc_rvalid <= loc_rd;
         if (loc_rd) begin
            case (loc_addr)
               ccc_pkg::ADDR_SELF_TEST_TALLY:    loc_rdata <= tally_q; // [RL1]
               ccc_pkg::ADDR_BACK_CHANNEL_SETUP: loc_rdata <= {bcs_q, rate_q};
               ccc_pkg::ADDR_PATH_CTL_FIRST:     loc_rdata <= pc1_q;
               ccc_pkg::ADDR_PATH_CTL_SECOND:    loc_rdata <= pc2_q;
               ccc_pkg::ADDR_REMOTE_TX_ADDR:     loc_rdata <= rta_q;
               default:                          loc_rdata <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transaction steering
   logic fwd_d;
   logic ack_d;

   always_comb begin
      fwd_d = txn_valid & (bcs_q[ccc_pkg::BCS_FWD_ALL_BIT] // [RL2]
              | (bcs_q[ccc_pkg::BCS_FWD_MATCH_BIT] & txn_addr_match)); // [RL3]
      ack_d = txn_valid & txn_is_write & bcs_q[ccc_pkg::BCS_SELF_ACK_BIT]; // [RL4]
   end

   // forward request, one cycle after the decode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txn_forward <= 1'b0;
      end else begin
         txn_forward <= fwd_d; // [RL2] [RL3]
      end
   end

   // local acknowledge, blind to lock and to the remote answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txn_self_ack <= 1'b0;
      end else begin
         txn_self_ack <= ack_d; // [RL4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // back channel controls
   // enable: forced on, or needed by either forwarding mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reverse_link_en <= 1'b1;
      end else begin
         reverse_link_en <= bcs_q[ccc_pkg::BCS_FORCE_ON_BIT]
                            | bcs_q[ccc_pkg::BCS_FWD_ALL_BIT]
                            | bcs_q[ccc_pkg::BCS_FWD_MATCH_BIT]; // [RL5]
      end
   end

   // check generation follows its bit directly
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reverse_link_check_gen_en <= 1'b1;
      end else begin
         reverse_link_check_gen_en <= bcs_q[ccc_pkg::BCS_CHECK_GEN_BIT]; // [RL7]
      end
   end

   // rate decode; reserved codes keep the previous rate
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reverse_link_rate_onehot <= ccc_pkg::RATE_OH_2M5;
      end else begin
         case (rate_q)
            ccc_pkg::RATE_2M5:  reverse_link_rate_onehot <= ccc_pkg::RATE_OH_2M5; // [RL8]
            ccc_pkg::RATE_10M:  reverse_link_rate_onehot <= ccc_pkg::RATE_OH_10M;
            ccc_pkg::RATE_25M:  reverse_link_rate_onehot <= ccc_pkg::RATE_OH_25M;
            ccc_pkg::RATE_50M:  reverse_link_rate_onehot <= ccc_pkg::RATE_OH_50M;
            ccc_pkg::RATE_100M: reverse_link_rate_onehot <= ccc_pkg::RATE_OH_100M;
            default:            reverse_link_rate_onehot <= reverse_link_rate_onehot; // [RL17]
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mirrored fields
   // gpio count decode: one, two or four lines, lowest first
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         forward_gpio_en <= 4'h0;
      end else begin
         case (pc1_q[ccc_pkg::PC1_GPIO_MSB:0])
            2'h0:    forward_gpio_en <= 4'h0; // [RL12]
            2'h1:    forward_gpio_en <= 4'h1;
            2'h2:    forward_gpio_en <= 4'h3;
            default: forward_gpio_en <= 4'hf;
         endcase
      end
   end

   // second path register handed to the datapath
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         path_setup_second <= 8'h00;
      end else begin
         path_setup_second <= pc2_q; // [RL14]
      end
   end

   // captured address without its lock bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         remote_transmitter_addr <= 7'h00;
      end else begin
         remote_transmitter_addr <= rta_q[7:1]; // [RL15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks: the read mux packs {bcs_q, rate_q}, the gpio
   // decode covers two bits and the address sits above its lock bit
   if (ccc_pkg::BCS_RATE_MSB + 1 != ccc_pkg::BCS_CHECK_GEN_BIT) begin : g_bad_rate_field
      $error("rate field must sit just below the check generation bit");
   end
   if (ccc_pkg::PC1_GPIO_MSB != 1) begin : g_bad_gpio_field
      $error("gpio count field must be two bits wide");
   end
   if (ccc_pkg::RTA_LOCK_BIT != 0) begin : g_bad_lock_bit
      $error("address lock must sit below the captured address");
   end
endmodule

// [rtl/ccc_sync2.sv]
`timescale 1ns/100ps
// two-flop synchroniser for a vector of independent levels
module ccc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

   // a synchroniser needs at least one line
   if (W < 1) begin : g_bad_width
      $error("synchroniser width must be at least one");
   end
endmodule

// [sim/ccc_regs_monitor.sv]
`timescale 1ns/100ps
// ties the bank outputs to the writes and loads that set them
module ccc_regs_monitor (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       loc_wr,
   input wire logic [7:0] loc_addr,
   input wire logic [7:0] loc_wdata,
   input wire logic       rem_wr,
   input wire logic [7:0] rem_addr,
   input wire logic       fwd_path_load,
   input wire logic       fwd_addr_load,
   input wire logic [6:0] fwd_remote_addr,
   input wire logic       txn_valid,
   input wire logic       txn_addr_match,
   input wire logic       txn_is_write,
   input wire logic       txn_forward,
   input wire logic       txn_self_ack,
   input wire logic       reverse_link_en,
   input wire logic       reverse_link_check_gen_en,
   input wire logic [4:0] reverse_link_rate_onehot,
   input wire logic [3:0] forward_gpio_en,
   input wire logic [7:0] path_setup_second,
   input wire logic [6:0] remote_transmitter_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic rta_quiet;
   // no write of either origin lands on the address register
   assign rta_quiet = !(loc_wr && loc_addr == ccc_pkg::ADDR_REMOTE_TX_ADDR)
      && !(rem_wr && rem_addr == ccc_pkg::ADDR_REMOTE_TX_ADDR);
   ////////////////////////////////////////
   // local writes that open the back-channel setup and address-lock checks
   sequence s_bcs_wr;
      loc_wr && loc_addr == ccc_pkg::ADDR_BACK_CHANNEL_SETUP;
   endsequence
   sequence s_rta_wr(lk);
      loc_wr && loc_addr == ccc_pkg::ADDR_REMOTE_TX_ADDR && loc_wdata[0] == lk;
   endsequence
   ////////////////////////////////////////
   a_forward_select: assert property (
      s_bcs_wr ##1 txn_valid |=> txn_forward ==
      ($past(loc_wdata[7], 2) || ($past(loc_wdata[6], 2) && $past(txn_addr_match))))
      else $error("forward decision wrong");
   a_self_ack_write: assert property (
      s_bcs_wr ##1 (txn_valid && txn_is_write) |=> txn_self_ack == $past(loc_wdata[5], 2))
      else $error("self ack wrong");
   a_back_chan_en: assert property (
      s_bcs_wr |-> ##2 reverse_link_en == (|$past(loc_wdata[7:6], 2) || $past(loc_wdata[4], 2)))
      else $error("back channel enable wrong");
   a_crc_gen_copy: assert property (
      s_bcs_wr |-> ##2 reverse_link_check_gen_en == $past(loc_wdata[3], 2))
      else $error("check generation enable wrong");
   a_rate_onehot: assert property (
      $onehot(reverse_link_rate_onehot))
      else $error("rate select not one-hot");
   a_gpio_kept_local: assert property (
      (loc_wr && loc_addr == ccc_pkg::ADDR_PATH_CTL_FIRST && loc_wdata[7]) |-> ##2
      forward_gpio_en == (($past(loc_wdata[1:0], 2) == 2'h3) ? 4'hf :
      {2'h0, $past(loc_wdata[1], 2), |$past(loc_wdata[1:0], 2)}))
      else $error("gpio enable wrong");
   a_second_written: assert property (
      (loc_wr && loc_addr == ccc_pkg::ADDR_PATH_CTL_SECOND) ##1 !fwd_path_load
      |=> path_setup_second == $past(loc_wdata, 2))
      else $error("second path register lost a write");
   a_addr_capture: assert property (
      s_rta_wr(1'b0) ##1 (fwd_addr_load && rta_quiet)
      |=> ##1 remote_transmitter_addr == $past(fwd_remote_addr, 2))
      else $error("remote address not captured");
   a_addr_frozen: assert property (
      s_rta_wr(1'b1) ##1 rta_quiet
      |=> ##1 remote_transmitter_addr == $past(loc_wdata[7:1], 3))
      else $error("locked remote address changed");
endmodule
bind ccc_regs ccc_regs_monitor u_mon (.*);

// [sim/ccc_remote_model.sv]
`timescale 1ns/100ps
// remote transmitter: forward loads and relayed register writes
module ccc_remote_model (
   input  wire logic       clk_sys,
   output logic            rem_wr,
   output logic      [7:0] rem_addr,
   output logic      [7:0] rem_wdata,
   output logic            fwd_path_load,
   output logic      [7:0] fwd_path_first,
   output logic      [7:0] fwd_path_second,
   output logic            fwd_addr_load,
   output logic      [6:0] fwd_remote_addr
);
   // idle strobes low, data lines at an arbitrary pattern
   initial begin
      {rem_wr, fwd_path_load, fwd_addr_load} = 3'h0;
      {rem_addr, rem_wdata, fwd_path_first, fwd_path_second} = 32'h5a3c_96e1;
      fwd_remote_addr = 7'h2b;
   end
   // each transfer: one strobe cycle, then data inverted once released
   task automatic send_path(input logic [7:0] f, input logic [7:0] s);
      @(negedge clk_sys);
      {fwd_path_first, fwd_path_second, fwd_path_load} = {f, s, 1'b1};
      @(negedge clk_sys);
      {fwd_path_first, fwd_path_second, fwd_path_load} = {~f, ~s, 1'b0};
   endtask
   task automatic send_addr(input logic [6:0] a);
      @(negedge clk_sys);
      {fwd_remote_addr, fwd_addr_load} = {a, 1'b1};
      @(negedge clk_sys);
      {fwd_remote_addr, fwd_addr_load} = {~a, 1'b0};
   endtask
   task automatic send_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {rem_addr, rem_wdata, rem_wr} = {a, d, 1'b1};
      @(negedge clk_sys);
      {rem_addr, rem_wdata, rem_wr} = {~a, ~d, 1'b0};
   endtask
endmodule

// [sim/control_channel_config_regs_test.sv]
`timescale 1ns/100ps
// self-checking bench for the configuration register bank
module control_channel_config_regs_test;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       loc_wr = 1'b0;
   logic       loc_rd = 1'b0;
   logic [7:0] loc_addr = 8'h00;
   logic [7:0] loc_wdata = 8'h00;
   logic       self_test_err = 1'b0;
   logic       self_test_clr = 1'b0;
   logic       power_down_active_low_pin = 1'b0;
   logic [2:0] rate_strap_pin = 3'h0;
   logic       txn_valid = 1'b0;
   logic       txn_addr_match = 1'b0;
   logic       txn_is_write = 1'b0;
   logic [7:0] loc_rdata, rem_addr, rem_wdata, fwd_path_first, fwd_path_second;
   logic [7:0] path_setup_second;
   logic       loc_rvalid, rem_wr, fwd_path_load, fwd_addr_load, txn_forward;
   logic       txn_self_ack, reverse_link_en, reverse_link_check_gen_en;
   logic [6:0] fwd_remote_addr, remote_transmitter_addr, a7;
   logic [4:0] reverse_link_rate_onehot, oh;
   logic [3:0] forward_gpio_en;
   logic [7:0] m [5];
   int         bad_count = 0;
   int         checks_done = 0;
   int         cyc = 0;
   int         n;
   always #12.5 clk_sys = ~clk_sys;
   ccc_regs dut (.*);
   ccc_remote_model far (.clk_sys, .rem_wr, .rem_addr, .rem_wdata, .fwd_path_load,
      .fwd_path_first, .fwd_path_second, .fwd_addr_load, .fwd_remote_addr);
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // expected rate select; reserved codes leave it as it was
   task automatic upd_rate;
      if (m[1][2:0] == 3'h0) oh = 5'h01;
      else if (m[1][2]) oh = 5'h02 << m[1][1:0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {loc_addr, loc_wdata, loc_wr} = {a, d, 1'b1};
      @(negedge clk_sys);
      loc_wr = 1'b0;
      if (a > 8'h57 && a < 8'h5c) m[a - 8'h57] = d;
      upd_rate;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_sys);
      {loc_addr, loc_rd} = {a, 1'b1};
      @(negedge clk_sys);
      loc_rd = 1'b0;
      chk("read valid", 8'(loc_rvalid), 8'h01);
      chk("read data", loc_rdata, (a > 8'h56 && a < 8'h5c) ? m[a - 8'h57] : 8'h00);
   endtask
   // every derived output against the model registers
   task automatic chk_outs;
      @(negedge clk_sys);
      chk("link enable", 8'(reverse_link_en), 8'(m[1][4] | m[1][7] | m[1][6]));
      chk("check gen", 8'(reverse_link_check_gen_en), 8'(m[1][3]));
      chk("rate", 8'(reverse_link_rate_onehot), 8'(oh));
      chk("gpio", 8'(forward_gpio_en),
         (m[2][1:0] == 2'h3) ? 8'h0f : 8'(m[2][1:0] + m[2][1]));
      chk("path second", path_setup_second, m[3]);
      chk("remote addr", 8'(remote_transmitter_addr), 8'(m[4][7:1]));
      chk("forward", 8'(txn_forward),
         8'(txn_valid & (m[1][7] | m[1][6] & txn_addr_match)));
      chk("self ack", 8'(txn_self_ack), 8'(txn_valid & txn_is_write & m[1][5]));
   endtask
   task automatic path_load(input logic [7:0] f, input logic [7:0] s);
      far.send_path(f, s);
      if (!m[2][7]) m[2][1:0] = f[1:0];
      if (!m[2][7]) m[3] = s;
   endtask
   task automatic addr_load(input logic [6:0] a);
      far.send_addr(a);
      if (!m[4][0]) m[4][7:1] = a;
   endtask
   ////////////////////////////////////////
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         end_of_test;
      end
   end
   // main sequence
   initial begin
      void'($urandom(32'hf673));
      m = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00};
      oh = 5'h01;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int a = 'h56; a < 'h5d; a++) rd(8'(a));
      chk_outs;
      rate_strap_pin = 3'($urandom_range(7, 4));
      @(negedge clk_sys);
      power_down_active_low_pin = 1'b1;
      repeat (6) @(negedge clk_sys);
      m[1][2:0] = rate_strap_pin;
      upd_rate;
      rd(8'h58);
      for (int c = 0; c < 8; c++) begin
         wr(8'h58, {5'h03, 3'(c)});
         chk_outs;
      end
      repeat (24) begin
         wr(8'h58, 8'($urandom));
         {txn_valid, txn_addr_match, txn_is_write} = 3'($urandom);
         chk_outs;
      end
      // remote rewrites after self-ack; force-on stays local
      wr(8'h58, 8'h20);
      foreach (m[i]) if (i < 2) begin
         far.send_write(8'h58, i ? 8'h10 : 8'hdf);
         m[1] = {(i ? 3'h0 : 3'h6), m[1][4], (i ? 4'h0 : 4'hf)};
         upd_rate;
         rd(8'h58);
         chk_outs;
      end
      // back-to-back errors, then a clear meeting an error
      n = $urandom_range(9, 2);
      @(negedge clk_sys);
      self_test_err = 1'b1;
      repeat (n) @(negedge clk_sys);
      self_test_err = 1'b0;
      m[0] = 8'(n);
      wr(8'h57, 8'hff);
      rd(8'h57);
      @(negedge clk_sys);
      {self_test_clr, self_test_err} = 2'h3;
      @(negedge clk_sys);
      {self_test_clr, self_test_err} = 2'h0;
      m[0] = 8'h01;
      rd(8'h57);
      for (int c = 0; c < 4; c++) begin
         path_load({6'h3f, 2'(c)}, 8'($urandom));
         chk_outs;
      end
      wr(8'h59, 8'hfe);
      wr(8'h5a, 8'h3c);
      path_load(8'h01, 8'h5a);
      rd(8'h59);
      rd(8'h5a);
      wr(8'h59, 8'h7c);
      path_load(8'hff, 8'h96);
      rd(8'h59);
      // control-channel write to the second path register
      far.send_write(8'h5a, 8'hc3);
      m[3] = 8'hc3;
      rd(8'h5a);
      // capture right behind an unlocking write, then locked
      a7 = 7'($urandom);
      fork
         wr(8'h5b, 8'h00);
         begin
            @(negedge clk_sys);
            addr_load(a7);
         end
      join
      rd(8'h5b);
      wr(8'h5b, 8'h81);
      addr_load(~a7);
      rd(8'h5b);
      chk_outs;
      end_of_test;
   end
endmodule
